// ==== bmr_defines.vh ====
// constants for the boot mode and reset pin block
`ifndef BMR_DEFINES_VH
`define BMR_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define BMR_OFS_RESET_CONTROL_ONE   8'h00
`define BMR_OFS_RESET_PIN_ONE_CFG   8'h04
`define BMR_OFS_RESET_PIN_TWO_CFG   8'h08
`define BMR_OFS_RESET_COUNTER_CTRL  8'h0C
`define BMR_OFS_BOOT_STATUS         8'h10
`define BMR_OFS_SW_RESET            8'h14

// ****************************************
// field positions
// ****************************************
`define BMR_CTL_PIN0_DIS_BIT        0
`define BMR_CFG_RESET_IN_BIT        0
`define BMR_CFG_LEVEL_BIT           1
`define BMR_CFG_INPUT_BIT           2
`define BMR_CFG_GPIO_BIT            3
`define BMR_SW_RESET_BIT            0

// ****************************************
// reset values
// ****************************************
`define BMR_CTL_RST                 16'h0000
`define BMR_CFG_RST                 16'h0004
`define BMR_RSTCNT_RST              8'h40

// ****************************************
// start-up modes and boot pin patterns
// ****************************************
`define BMR_MODE_FLASH              3'h0
`define BMR_MODE_UART               3'h1
`define BMR_MODE_CAN                3'h2
`define BMR_MODE_SPI                3'h3
`define BMR_MODE_NONE               3'h4
`define BMR_PAT_FLASH               2'h3
`define BMR_PAT_UART                3'h6
`define BMR_PAT_CAN                 3'h5
`define BMR_PAT_SPI                 4'h9

// ****************************************
// timing
// ****************************************
`define BMR_CLK_PERIOD_NS           10
`define BMR_POR_REJECT_NS           10
`define BMR_POR_DETECT_NS           100
`define BMR_POR_REJECT_CYC ((`BMR_POR_REJECT_NS + `BMR_CLK_PERIOD_NS - 1) / `BMR_CLK_PERIOD_NS)
`define BMR_POR_DETECT_CYC (`BMR_POR_DETECT_NS / `BMR_CLK_PERIOD_NS)
`define BMR_POR_LOW_CYC    (`BMR_POR_REJECT_CYC + 1)
`define BMR_POR_HOLD_CYC            256
`define BMR_GUARD_CYC               8

`endif

// ==== bmr_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module bmr_sync #(
  parameter W = 8
) (
  input  wire         i_ref_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // pins idle high, so both stages reset to ones
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= {W{1'b1}};
      o_sync <= {W{1'b1}};
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// ==== bmr_por_filter.v ====
// glitch filter for the synchronised power-on reset pin
`timescale 1ns/1ns
module bmr_por_filter #(
  parameter LOW_CYC = 2
) (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_pin_n,
  output reg  o_por_req
);
  reg [3:0] cnt;

  // a low must last LOW_CYC samples; single-sample glitches are dropped
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt       <= 4'h0;
      o_por_req <= 1'b0;
    end else if (i_pin_n) begin
      cnt       <= 4'h0;
      o_por_req <= 1'b0;
    end else if (cnt == LOW_CYC[3:0] - 4'h1) begin
      o_por_req <= 1'b1;
    end else begin
      cnt       <= cnt + 4'h1;
    end
  end
endmodule

// ==== bmr_top.v ====
// boot mode selection and reset pin control with a wishbone register slave
//
// Behaviour
// - boot pins low two 11: flash start
// - boot pins low three 110: uart loader
// - boot pins low three 101: can loader
// - boot pins low four 1001: spi loader
// - select mode after power-on and application reset
// - pin zero defaults to open-drain reset input
// - pin zero driven low while counter runs
// - pins one, two: inputs, pull-up, no reset
// - config field zero: open-drain reset output
// - gpio pin outputs written level, zero pulses
// - only external pin raises power-on reset
// - 0x000A makes pin push-pull high
// - filter drops short lows, catches long lows
// - control bit disables pin zero reset function
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
`include "bmr_defines.vh"
module bmr_top #(
  parameter POR_HOLD_CYC = `BMR_POR_HOLD_CYC,
  parameter GUARD_CYC    = `BMR_GUARD_CYC
) (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  input  wire        i_power_on_reset_pin_n,
  input  wire [3:0]  i_boot_config_port,
  input  wire        i_ext_reset_pin_zero,
  input  wire        i_ext_reset_pin_one,
  input  wire        i_ext_reset_pin_two,
  input  wire        i_watchdog_timer_reset,
  output reg         o_ext_reset_pin_zero,
  output reg         o_ext_reset_pin_zero_oe_n,
  output reg         o_ext_reset_pin_zero_pullup,
  output reg         o_ext_reset_pin_one,
  output reg         o_ext_reset_pin_one_oe_n,
  output reg         o_ext_reset_pin_one_pullup,
  output reg         o_ext_reset_pin_two,
  output reg         o_ext_reset_pin_two_oe_n,
  output reg         o_ext_reset_pin_two_pullup,
  output reg         o_app_reset,
  output reg         o_power_on_reset,
  output reg  [2:0]  o_boot_mode,
  output reg         o_boot_valid
);

  // ****************************************
  // states
  // ****************************************
  localparam ST_RUN   = 2'h0;
  localparam ST_RESET = 2'h1;
  localparam ST_GUARD = 2'h2;

  // ****************************************
  // functions
  // ****************************************
  // byte-lane merge for the 16-bit registers
  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? new_val[15:8] : old_val[15:8],
                 sel[0] ? new_val[7:0]  : old_val[7:0]};
    end
  endfunction

  function [2:0] decode_mode;
    input [3:0] pins;
    begin
      if (pins[1:0] == `BMR_PAT_FLASH)
        decode_mode = `BMR_MODE_FLASH;
      else if (pins[2:0] == `BMR_PAT_UART)
        decode_mode = `BMR_MODE_UART;
      else if (pins[2:0] == `BMR_PAT_CAN)
        decode_mode = `BMR_MODE_CAN;
      else if (pins == `BMR_PAT_SPI)
        decode_mode = `BMR_MODE_SPI;
      else
        decode_mode = `BMR_MODE_NONE;
    end
  endfunction

  // pin drive {level, oe_n, pullup} for a configurable reset pin
  function [2:0] pin_drive;
    input [15:0] cfg;
    input        asserting;
    begin
      if (cfg[`BMR_CFG_GPIO_BIT])
        pin_drive = {cfg[`BMR_CFG_LEVEL_BIT], 1'b0, 1'b0};
      else if (cfg[`BMR_CFG_INPUT_BIT])
        pin_drive = 3'h3;
      else
        pin_drive = {1'b0, ~asserting, 1'b1};
    end
  endfunction

  // ****************************************
  // pin inputs
  // ****************************************
  wire [7:0] pins_sync;
  wire       por_req;

  bmr_sync #(
    .W (8)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_power_on_reset_pin_n, i_ext_reset_pin_two, i_ext_reset_pin_one,
                 i_ext_reset_pin_zero, i_boot_config_port}),
    .o_sync    (pins_sync)
  );

  bmr_por_filter #(
    .LOW_CYC (`BMR_POR_LOW_CYC)
  ) u_por_filter (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_pin_n   (pins_sync[7]),
    .o_por_req (por_req)
  );

  wire [3:0] boot_pins = pins_sync[3:0];
  wire       pin0_in   = pins_sync[4];
  wire       pin1_in   = pins_sync[5];
  wire       pin2_in   = pins_sync[6];

  // ****************************************
  // registers
  // ****************************************
  reg [1:0]  state;
  reg        por_phase;
  reg [11:0] cnt;
  reg [3:0]  guard;
  reg [15:0] ctl;
  reg [15:0] cfg1;
  reg [15:0] cfg2;
  reg [7:0]  app_count;
  reg        sw_req;
  reg        last_por;
  reg [3:0]  boot_raw;

  wire wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // writes land on the ack edge, where the master takes the transfer as done
  wire wb_wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  wire pin0_dis  = ctl[`BMR_CTL_PIN0_DIS_BIT];
  wire asserting = (state == ST_RESET);

  // resets from pins are only heard in run; own drive would otherwise retrigger
  wire req_pin0 = ~pin0_dis & ~pin0_in;
  wire req_pin1 = cfg1[`BMR_CFG_RESET_IN_BIT] & ~cfg1[`BMR_CFG_GPIO_BIT] & ~pin1_in;
  wire req_pin2 = cfg2[`BMR_CFG_RESET_IN_BIT] & ~cfg2[`BMR_CFG_GPIO_BIT] & ~pin2_in;
  wire app_req  = (state == ST_RUN) &
                  (req_pin0 | req_pin1 | req_pin2 | i_watchdog_timer_reset | sw_req);

  // ****************************************
  // reset sequencer
  // ****************************************
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state        <= ST_RESET;
      por_phase    <= 1'b1;
      cnt          <= POR_HOLD_CYC[11:0] - 12'h1;
      guard        <= 4'h0;
      last_por     <= 1'b1;
      boot_raw     <= 4'h0;
      o_boot_mode  <= `BMR_MODE_NONE;
      o_boot_valid <= 1'b0;
    end else if (por_req) begin
      // power-on comes from the pin only, nothing inside can start one
      state        <= ST_RESET;
      por_phase    <= 1'b1;
      cnt          <= POR_HOLD_CYC[11:0] - 12'h1;
      o_boot_valid <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (app_req) begin
            state        <= ST_RESET;
            por_phase    <= 1'b0;
            cnt          <= {4'h0, app_count};
            o_boot_valid <= 1'b0;
          end
        end
        ST_RESET: begin
          if (cnt == 12'h0) begin
            state        <= ST_GUARD;
            guard        <= GUARD_CYC[3:0] - 4'h1;
            last_por     <= por_phase;
            boot_raw     <= boot_pins;
            o_boot_mode  <= decode_mode(boot_pins);
            o_boot_valid <= 1'b1;
          end else begin
            cnt <= cnt - 12'h1;
          end
        end
        ST_GUARD: begin
          // lets the released pins rise through the synchroniser
          if (guard == 4'h0)
            state <= ST_RUN;
          else
            guard <= guard - 4'h1;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // ****************************************
  // pin and reset outputs
  // ****************************************
  wire [2:0] drive1 = pin_drive(cfg1, asserting);
  wire [2:0] drive2 = pin_drive(cfg2, asserting);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_reset_pin_zero        <= 1'b0;
      o_ext_reset_pin_zero_oe_n   <= 1'b1;
      o_ext_reset_pin_zero_pullup <= 1'b1;
      o_ext_reset_pin_one         <= 1'b1;
      o_ext_reset_pin_one_oe_n    <= 1'b1;
      o_ext_reset_pin_one_pullup  <= 1'b1;
      o_ext_reset_pin_two         <= 1'b1;
      o_ext_reset_pin_two_oe_n    <= 1'b1;
      o_ext_reset_pin_two_pullup  <= 1'b1;
      o_app_reset                 <= 1'b1;
      o_power_on_reset            <= 1'b1;
    end else begin
      o_ext_reset_pin_zero        <= 1'b0;
      o_ext_reset_pin_zero_oe_n   <= ~(asserting & (por_phase | ~pin0_dis));
      o_ext_reset_pin_zero_pullup <= 1'b1;
      o_ext_reset_pin_one         <= drive1[2];
      o_ext_reset_pin_one_oe_n    <= drive1[1];
      o_ext_reset_pin_one_pullup  <= drive1[0];
      o_ext_reset_pin_two         <= drive2[2];
      o_ext_reset_pin_two_oe_n    <= drive2[1];
      o_ext_reset_pin_two_pullup  <= drive2[0];
      o_app_reset                 <= asserting | por_req;
      o_power_on_reset            <= (asserting & por_phase) | por_req;
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  reg [31:0] rd_data;

  always @* begin
    rd_data = 32'h0000_0000;
    case (i_wb_adr)
      `BMR_OFS_RESET_CONTROL_ONE:  rd_data = {16'h0000, ctl};
      `BMR_OFS_RESET_PIN_ONE_CFG:  rd_data = {16'h0000, cfg1};
      `BMR_OFS_RESET_PIN_TWO_CFG:  rd_data = {16'h0000, cfg2};
      `BMR_OFS_RESET_COUNTER_CTRL: rd_data = {24'h000000, app_count};
      `BMR_OFS_BOOT_STATUS:        rd_data = {23'h0, last_por, boot_raw,
                                              o_boot_valid, o_boot_mode};
      `BMR_OFS_SW_RESET:           rd_data = {31'h0, sw_req};
      default:                     rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  // configuration survives application resets so a pin can signal them;
  // only a power-on puts it back to defaults
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl       <= `BMR_CTL_RST;
      cfg1      <= `BMR_CFG_RST;
      cfg2      <= `BMR_CFG_RST;
      app_count <= `BMR_RSTCNT_RST;
      sw_req    <= 1'b0;
    end else if (por_req) begin
      ctl       <= `BMR_CTL_RST;
      cfg1      <= `BMR_CFG_RST;
      cfg2      <= `BMR_CFG_RST;
      app_count <= `BMR_RSTCNT_RST;
      sw_req    <= 1'b0;
    end else begin
      if (wb_wr && i_wb_adr == `BMR_OFS_RESET_CONTROL_ONE)
        ctl <= merge16(ctl, i_wb_dat[15:0], i_wb_sel[1:0]);
      if (wb_wr && i_wb_adr == `BMR_OFS_RESET_PIN_ONE_CFG)
        cfg1 <= merge16(cfg1, i_wb_dat[15:0], i_wb_sel[1:0]);
      if (wb_wr && i_wb_adr == `BMR_OFS_RESET_PIN_TWO_CFG)
        cfg2 <= merge16(cfg2, i_wb_dat[15:0], i_wb_sel[1:0]);
      if (wb_wr && i_wb_adr == `BMR_OFS_RESET_COUNTER_CTRL && i_wb_sel[0])
        app_count <= i_wb_dat[7:0];
      // a new request wins over the clear on being taken
      if (wb_wr && i_wb_adr == `BMR_OFS_SW_RESET && i_wb_sel[0] &&
          i_wb_dat[`BMR_SW_RESET_BIT])
        sw_req <= 1'b1;
      else if (app_req)
        sw_req <= 1'b0;
    end
  end

endmodule

// ==== bmr_top_sva.sv ====
// assertions for the boot mode and reset pin block
`timescale 1ns/1ns
`include "bmr_defines.vh"
module bmr_top_sva (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       o_wb_ack,
  input wire logic       i_power_on_reset_pin_n,
  input wire logic [3:0] i_boot_config_port,
  input wire logic       o_ext_reset_pin_zero,
  input wire logic       o_ext_reset_pin_zero_oe_n,
  input wire logic       o_ext_reset_pin_one_oe_n,
  input wire logic       o_ext_reset_pin_one_pullup,
  input wire logic       o_ext_reset_pin_two_oe_n,
  input wire logic       o_ext_reset_pin_two_pullup,
  input wire logic       o_app_reset,
  input wire logic       o_power_on_reset,
  input wire logic [2:0] o_boot_mode,
  input wire logic       o_boot_valid
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // ****
  // helpers
  // ****
  // cycles since the power-on pin was last low, saturating
  logic [3:0] since_low;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) since_low <= 4'hF;
    else if (!i_power_on_reset_pin_n) since_low <= 4'h0;
    else if (since_low != 4'hF) since_low <= since_low + 4'h1;
  end
  // pins held long enough to pass the synchroniser before the latch
  sequence s_held(c);
    (c && $stable(i_boot_config_port))[*6];
  endsequence
  sequence s_por_held;
    o_power_on_reset[*3];
  endsequence
  // ****
  // properties
  // ****
  property p_ack_once;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  property p_flash;
    s_held(i_boot_config_port[1:0] == 2'h3) ##0 $rose(o_boot_valid)
      |-> o_boot_mode == `BMR_MODE_FLASH;
  endproperty
  property p_uart;
    s_held(i_boot_config_port[2:0] == 3'h6) ##0 $rose(o_boot_valid)
      |-> o_boot_mode == `BMR_MODE_UART;
  endproperty
  property p_can;
    s_held(i_boot_config_port[2:0] == 3'h5) ##0 $rose(o_boot_valid)
      |-> o_boot_mode == `BMR_MODE_CAN;
  endproperty
  property p_spi;
    s_held(i_boot_config_port == 4'h9) ##0 $rose(o_boot_valid)
      |-> o_boot_mode == `BMR_MODE_SPI;
  endproperty
  property p_mode_hold;
    (!o_app_reset)[*3] |-> $stable(o_boot_mode);
  endproperty
  property p_pin0_por;
    s_por_held |-> !o_ext_reset_pin_zero_oe_n;
  endproperty
  property p_pin0_od;
    !o_ext_reset_pin_zero_oe_n |-> !o_ext_reset_pin_zero && o_app_reset;
  endproperty
  property p_por_pins;
    s_por_held |-> o_ext_reset_pin_one_oe_n && o_ext_reset_pin_one_pullup
      && o_ext_reset_pin_two_oe_n && o_ext_reset_pin_two_pullup;
  endproperty
  property p_por_cause;
    $rose(o_power_on_reset) |-> since_low < 4'hC;
  endproperty
  property p_por_catch;
    $fell(i_power_on_reset_pin_n) ##1 (!i_power_on_reset_pin_n)[*8]
      |-> ##[0:4] o_power_on_reset;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
  a_flash: assert property (p_flash) else $error("flash pattern, wrong mode");
  a_uart: assert property (p_uart) else $error("uart pattern, wrong mode");
  a_can: assert property (p_can) else $error("can pattern, wrong mode");
  a_spi: assert property (p_spi) else $error("spi pattern, wrong mode");
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved in run");
  a_pin0_por: assert property (p_pin0_por) else $error("pin zero not low");
  a_pin0_od: assert property (p_pin0_od) else $error("pin zero driven outside reset");
  a_por_pins: assert property (p_por_pins) else $error("pins one/two not inputs");
  a_por_cause: assert property (p_por_cause) else $error("power-on without pin");
  a_por_catch: assert property (p_por_catch) else $error("long low missed");
endmodule
bind bmr_top bmr_top_sva u_sva (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack,
  .i_power_on_reset_pin_n, .i_boot_config_port, .o_ext_reset_pin_zero,
  .o_ext_reset_pin_zero_oe_n, .o_ext_reset_pin_one_oe_n, .o_ext_reset_pin_one_pullup,
  .o_ext_reset_pin_two_oe_n, .o_ext_reset_pin_two_pullup, .o_app_reset,
  .o_power_on_reset, .o_boot_mode, .o_boot_valid);

// ==== bmr_board.sv ====
// board reset nets and supply supervisor model
`timescale 1ns/1ns
module bmr_board (
  input  wire logic i_p0_out,
  input  wire logic i_p0_oe_n,
  input  wire logic i_p1_out,
  input  wire logic i_p1_oe_n,
  input  wire logic i_p2_out,
  input  wire logic i_p2_oe_n,
  input  wire logic i_button_n,
  input  wire logic i_supervisor_n,
  output wire logic o_p0,
  output wire logic o_p1,
  output wire logic o_p2,
  output wire logic o_por_n
);
  // nets zero and one carry board pull-ups, so released means high
  assign o_p0 = (i_p0_oe_n | i_p0_out) & i_button_n;
  assign o_p1 = i_p1_oe_n | i_p1_out;
  // strong pull-down beats the weak internal pull-up until driven high
  assign o_p2 = !i_p2_oe_n & i_p2_out;
  // net one is tied to the power-on pin beside the supervisor
  assign o_por_n = o_p1 & i_supervisor_n;
endmodule

// ==== bmr_top_tb_top.sv ====
// self-checking testbench for the boot mode and reset pin block
`timescale 1ns/1ns
`include "bmr_defines.vh"
module bmr_top_tb_top;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, wdt = 0, btn_n = 1, sup_n = 1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd;
  logic [3:0]  boot = 4'hF;
  wire  [31:0] dat;
  wire         ack, p0, p1, p2, por_n, p0o, p0e, p0u, p1o, p1e, p1u, p2o, p2e, p2u;
  wire         app, por, valid;
  wire  [2:0]  mode;
  int          err_count = 0, n_tests = 0;
  bit          hit;
  always #5 clk = ~clk;
  // short power-on hold keeps the run brief
  bmr_top #(.POR_HOLD_CYC(16), .GUARD_CYC(8)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(dat), .o_wb_ack(ack), .i_power_on_reset_pin_n(por_n),
    .i_boot_config_port(boot), .i_ext_reset_pin_zero(p0), .i_ext_reset_pin_one(p1),
    .i_ext_reset_pin_two(p2), .i_watchdog_timer_reset(wdt), .o_ext_reset_pin_zero(p0o),
    .o_ext_reset_pin_zero_oe_n(p0e), .o_ext_reset_pin_zero_pullup(p0u),
    .o_ext_reset_pin_one(p1o), .o_ext_reset_pin_one_oe_n(p1e),
    .o_ext_reset_pin_one_pullup(p1u), .o_ext_reset_pin_two(p2o),
    .o_ext_reset_pin_two_oe_n(p2e), .o_ext_reset_pin_two_pullup(p2u), .o_app_reset(app),
    .o_power_on_reset(por), .o_boot_mode(mode), .o_boot_valid(valid));
  bmr_board board (.i_p0_out(p0o), .i_p0_oe_n(p0e), .i_p1_out(p1o), .i_p1_oe_n(p1e),
    .i_p2_out(p2o), .i_p2_oe_n(p2e), .i_button_n(btn_n), .i_supervisor_n(sup_n),
    .o_p0(p0), .o_p1(p1), .o_p2(p2), .o_por_n(por_n));
  // ****
  // shared tasks
  // ****
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // called just after a rising edge; ack and data are taken at one edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    repeat (20) if (ack !== 1'b1) @(posedge clk);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk(ack, 1'b1, "bus answer");
      wrap_up();
    end
    @(posedge clk);
  endtask
  task automatic wait_app(input logic lvl, input int lim, output bit got);
    repeat (lim) if (app !== lvl) @(posedge clk);
    got = (app === lvl);
  endtask
  task automatic settle;
    wait_app(1'b0, 2000, hit);
    repeat (400) if (valid !== 1'b1) @(posedge clk);
    chk({hit, valid}, 2'b11, "sequence finished");
    if (!hit || valid !== 1'b1) wrap_up();
    repeat (12) @(posedge clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power_up;
    logic [7:0]  a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18};
    logic [31:0] e[5] = '{`BMR_CTL_RST, `BMR_CFG_RST, `BMR_CFG_RST, `BMR_RSTCNT_RST, 0};
    repeat (2) @(posedge clk);
    chk({p0o, p0e}, 2'b00, "pin zero low at power-up");
    settle();
    chk({p0e, p0u, p1e, p1u, p2e, p2u}, 6'h3F, "pins released, pull-ups");
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      chk(rd, e[i], "register reset value");
    end
    wb(1'b0, 8'h10, 32'h0);
    chk(rd[3:0], {1'b1, `BMR_MODE_FLASH}, "flash start");
    $display("power-up test done");
  endtask
  task automatic t_boot_modes;
    logic [3:0] pat[5] = '{4'hB, 4'h6, 4'h5, 4'h9, 4'h0};
    logic [2:0] exp[5] = '{`BMR_MODE_FLASH, `BMR_MODE_UART, `BMR_MODE_CAN,
                           `BMR_MODE_SPI, `BMR_MODE_NONE};
    foreach (pat[i]) begin
      boot <= pat[i];
      wb(1'b1, 8'h14, 32'h1);
      wait_app(1'b1, 10, hit);
      chk({hit, por}, 2'b10, "software reset, no power-on");
      if (!hit) wrap_up();
      settle();
      chk(mode, exp[i], "mode");
      boot <= ~pat[i];
      repeat (8) @(posedge clk);
      chk(mode, exp[i], "mode held");
    end
    $display("boot mode test done");
  endtask
  task automatic t_wdt_por;
    wb(1'b1, 8'h0C, 32'hFF);
    wb(1'b1, 8'h04, 32'h0);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    wait_app(1'b1, 10, hit);
    @(posedge clk);
    chk({hit, p1e, p1o}, 3'b100, "pin one driven low in reset");
    repeat (20) if (por !== 1'b1) @(posedge clk);
    chk(por, 1'b1, "power-on through pin one");
    if (!hit || por !== 1'b1) wrap_up();
    settle();
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, `BMR_CFG_RST, "config back to input");
    $display("watchdog power-on test done");
  endtask
  task automatic t_gpio;
    chk(p2, 1'b0, "reset-out held low");
    wb(1'b1, 8'h08, 32'hA);
    repeat (2) @(posedge clk);
    chk({p2o, p2e, p2u, p2}, 4'b1001, "push-pull high");
    wb(1'b1, 8'h08, 32'h8);
    wait_app(1'b1, 12, hit);
    chk({hit, p2o, p2}, 3'b000, "written low, no reset");
    wb(1'b1, 8'h08, 32'h4);
    $display("gpio test done");
  endtask
  task automatic t_filter;
    sup_n <= 1'b0;
    @(posedge clk);
    sup_n <= 1'b1;
    wait_app(1'b1, 12, hit);
    chk(hit, 1'b0, "glitch ignored");
    sup_n <= 1'b0;
    repeat (11) @(posedge clk);
    sup_n <= 1'b1;
    chk(por, 1'b1, "long low caught");
    settle();
    $display("filter test done");
  endtask
  task automatic t_pin0;
    btn_n <= 1'b0;
    repeat (4) @(posedge clk);
    btn_n <= 1'b1;
    wait_app(1'b1, 10, hit);
    chk({hit, por}, 2'b10, "pin zero reset input");
    if (!hit) wrap_up();
    settle();
    wb(1'b1, 8'h00, 32'h1);
    btn_n <= 1'b0;
    repeat (4) @(posedge clk);
    btn_n <= 1'b1;
    wait_app(1'b1, 12, hit);
    chk(hit, 1'b0, "pin zero reset disabled");
    wb(1'b1, 8'h00, 32'h0);
    $display("pin zero test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_boot_modes();
    t_wdt_por();
    t_gpio();
    t_filter();
    t_pin0();
    wrap_up();
  end
endmodule
